// file: pkg/psq_defines.svh
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH

// ==========================================================
// Clock, phase 1 timing and asynchronous word period.
// ==========================================================
`define PSQ_CLK_MHZ 10
`define PSQ_SETTLE_US 2000
`define PSQ_FILT_START_US 3000
`define PSQ_PME_END_US 20000
`define PSQ_INIT2_US 25000
`define PSQ_ASYNC_PERIOD_US 228

// ==========================================================
// Phase 2 sequence figures.
// ==========================================================
`define PSQ_K_SYNC 4'h4
`define PSQ_K_ASYNC 4'h8
`define PSQ_FIELDS_STD 6'h20
`define PSQ_FIELDS_EXT 6'h30
`define PSQ_ID_BASE 10'h20f
`define PSQ_DATA_BASE 10'h21f
`define PSQ_BLKCNT_STD 4'h2
`define PSQ_BLKCNT_EXT 4'h3
`define PSQ_BLKCNT_LOW 4'h0
`define PSQ_RSVD_NIBBLE 4'h0
`define PSQ_LAST_SLOT 2'h3

`endif

// file: pkg/psq_pkg.sv
package psq_pkg;

   typedef enum logic [2:0] {
      ST_SETTLE,
      ST_FILTER,
      ST_PME,
      ST_WAIT2,
      ST_PHASE2,
      ST_DONE,
      ST_PROG
   } psq_state_t;

   typedef struct packed {
      logic [7:0] user_byte_8;
      logic [7:0] user_byte_7;
      logic [7:0] user_byte_6;
      logic [7:0] user_byte_5;
      logic [7:0] user_byte_4;
      logic [7:0] user_byte_3;
      logic [7:0] user_byte_2;
      logic [7:0] user_byte_1;
      logic [7:0] user_byte_0;
      logic [7:0] serial_byte_4;
      logic [7:0] serial_byte_3;
      logic [7:0] serial_byte_2;
      logic [7:0] serial_byte_1;
      logic [7:0] serial_byte_0;
      logic [7:0] part_code_byte_1;
      logic [7:0] part_code_byte_0;
   } psq_ident_t;

   typedef struct packed {
      logic [1:0] slot;
      logic [9:0] code;
   } psq_tx_t;

endpackage

// file: rtl/psq_word_buffer.sv
`timescale 1ns/100ps

// ==========================================================
// Two-entry buffer: a head register and a spare register.
// ==========================================================
module psq_word_buffer #(
   parameter int WIDTH = 12
) (
   input wire logic clk,                 // System clock.
   input wire logic rst,                 // Synchronous reset.
   input wire logic in_valid,            // Source offers a word.
   output logic in_ready_reg,            // Buffer can take a word.
   input wire logic [WIDTH-1:0] in_data, // Offered word.
   output logic out_valid_reg,           // Head word is valid.
   input wire logic out_ready,           // Sink takes the head word.
   output logic [WIDTH-1:0] out_data_reg // Head word.
);

   logic [WIDTH-1:0] spare_reg;
   logic spare_valid_reg;

   // The spare holds a word that arrived while the sink stalled.
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
         spare_reg <= '0;
         spare_valid_reg <= 1'b0;
      end else if (!out_valid_reg || out_ready) begin
         if (spare_valid_reg) begin
            out_data_reg <= spare_reg;
            out_valid_reg <= 1'b1;
            spare_valid_reg <= 1'b0;
         end else if (in_valid) begin
            out_data_reg <= in_data;
            out_valid_reg <= 1'b1;
         end else begin
            out_valid_reg <= 1'b0;
         end
      end else if (in_valid && !spare_valid_reg) begin
         spare_reg <= in_data;
         spare_valid_reg <= 1'b1;
      end
   end

   // Ready drops on the same edge that the spare fills.
   always_ff @(posedge clk) begin
      if (rst) begin
         in_ready_reg <= 1'b1;
      end else if (!out_valid_reg || out_ready) begin
         in_ready_reg <= 1'b1;
      end else begin
         in_ready_reg <= spare_valid_reg || !in_valid ? !spare_valid_reg : 1'b0;
      end
   end

endmodule

// file: rtl/psq_init_seq.sv
// Function
// - Phase 1 runs initialization and self checks and sends nothing.
// - Phase 1: settle delay, then filter start, then watch entry window.
// - Without programming entry, go to phase 2 at its start time.
// - Phase 2 keeps self checks running and sends init ID and data codes.
// - Per field in order: ID word, data word, pair repeated k times.
// - Send 32 fields, or 48 when extended selection is set.
// - Phase 2 length is two words times k times fields times period.
// - Asynchronous 228 us period uses k of 8.
// - Synchronous 500 us period uses k of 4.
// - Nibbles 2 and 3 carry block count 0010 0000 or 0011 0000.
// - Nibble 1 user byte 0 low; nibbles 4-7 user bytes 1, 2 low first.
// - Nibbles 8-13 user bytes 3-5 low first; byte 6 in 14 and 32.
// - Nibbles 15-18 carry user bytes 7 and 8, low half first.
// - Nibbles 19-28 carry serial bytes 4 down to 0, high half first.
// - Nibble 29 part byte 1 low; nibbles 30, 31 part byte 0 high first.
// - Each nibble carries a 4-bit address, page 0 then page 1.
// - Data nibble 0000..1111 encodes as 21Fh down to 210h.
// - Block ID 1..16 encodes as 20Fh down to 200h.
// - Synchronous: send for each enabled slot; asynchronous: slot 0 only.
// - Reserved fields beyond 32 send a fixed constant.
`timescale 1ns/100ps
`include "psq_defines.svh"

module psq_init_seq #(
   parameter int SETTLE_CYC = `PSQ_SETTLE_US * `PSQ_CLK_MHZ,
   parameter int FILT_START_CYC = `PSQ_FILT_START_US * `PSQ_CLK_MHZ,
   parameter int PME_END_CYC = `PSQ_PME_END_US * `PSQ_CLK_MHZ,
   parameter int INIT2_CYC = `PSQ_INIT2_US * `PSQ_CLK_MHZ,
   parameter int ASYNC_PERIOD_CYC = `PSQ_ASYNC_PERIOD_US * `PSQ_CLK_MHZ,
   parameter logic [3:0] RSVD_NIBBLE = `PSQ_RSVD_NIBBLE
) (
   input wire logic CLK_SYS,                 // System clock, 10 MHz.
   input wire logic RST,                     // Synchronous reset, high.
   input wire logic SYNC_MODE,               // High for synchronous operation.
   input wire logic EXTENDED_FIELD_COUNT_SEL, // Send 48 fields when high.
   input wire logic [3:0] SLOT_EN,           // Enabled source slots.
   input wire logic SYNC_PULSE,              // Sync pulse from the link pin.
   input wire logic PROG_ENTRY_DET,          // Entry sequence recognized.
   input wire psq_pkg::psq_ident_t IDENT,    // User, serial and part bytes.
   output logic TX_VALID,                    // Word offered to transmitter.
   input wire logic TX_READY,                // Transmitter takes the word.
   output psq_pkg::psq_tx_t TX_DATA,         // Slot and 10-bit code.
   output logic SELF_CHECK_EN,               // Self checks running.
   output logic REF_FILTER_START,            // Filter init start, one pulse.
   output logic PROG_WINDOW_OPEN,            // Entry window open.
   output logic PROG_MODE,                   // Programming mode entered.
   output logic PHASE2_ACTIVE,               // Phase 2 in progress.
   output logic PHASE2_DONE                  // Phase 2 finished.
);

   // ==========================================================
   // State and counters.
   // ==========================================================
   psq_pkg::psq_state_t state_reg;
   logic [31:0] timer_reg;
   logic [31:0] div_reg;
   logic sync_s1_reg;
   logic sync_s2_reg;
   logic sync_s3_reg;
   logic tick_reg;
   logic mode_sync_reg;
   logic ext_reg;
   logic [5:0] field_reg;
   logic [3:0] rep_reg;
   logic half_reg;
   logic busy_reg;
   logic [1:0] slot_reg;
   logic [9:0] word_reg;
   logic [3:0] k_val;
   logic [5:0] n_fields;
   logic slot_on;
   logic push;
   logic buf_ready;
   logic last_word;
   psq_pkg::psq_tx_t buf_in;

   // ==========================================================
   // Nibble contents by nibble index, zero based.
   // ==========================================================
   function automatic logic [3:0] nibble_of(
      input logic [5:0] idx,
      input logic ext,
      input psq_pkg::psq_ident_t id
   );
      logic [3:0] v;
      v = RSVD_NIBBLE;
      case (idx)
         6'h00: v = id.user_byte_0[3:0];
         6'h01: v = ext ? `PSQ_BLKCNT_EXT : `PSQ_BLKCNT_STD;
         6'h02: v = `PSQ_BLKCNT_LOW;
         6'h03: v = id.user_byte_1[3:0];
         6'h04: v = id.user_byte_1[7:4];
         6'h05: v = id.user_byte_2[3:0];
         6'h06: v = id.user_byte_2[7:4];
         6'h07: v = id.user_byte_3[3:0];
         6'h08: v = id.user_byte_3[7:4];
         6'h09: v = id.user_byte_4[3:0];
         6'h0a: v = id.user_byte_4[7:4];
         6'h0b: v = id.user_byte_5[3:0];
         6'h0c: v = id.user_byte_5[7:4];
         6'h0d: v = id.user_byte_6[3:0];
         6'h0e: v = id.user_byte_7[3:0];
         6'h0f: v = id.user_byte_7[7:4];
         6'h10: v = id.user_byte_8[3:0];
         6'h11: v = id.user_byte_8[7:4];
         6'h12: v = id.serial_byte_4[7:4];
         6'h13: v = id.serial_byte_4[3:0];
         6'h14: v = id.serial_byte_3[7:4];
         6'h15: v = id.serial_byte_3[3:0];
         6'h16: v = id.serial_byte_2[7:4];
         6'h17: v = id.serial_byte_2[3:0];
         6'h18: v = id.serial_byte_1[7:4];
         6'h19: v = id.serial_byte_1[3:0];
         6'h1a: v = id.serial_byte_0[7:4];
         6'h1b: v = id.serial_byte_0[3:0];
         6'h1c: v = id.part_code_byte_1[3:0];
         6'h1d: v = id.part_code_byte_0[7:4];
         6'h1e: v = id.part_code_byte_0[3:0];
         6'h1f: v = id.user_byte_6[7:4];
         default: v = RSVD_NIBBLE;
      endcase
      return v;
   endfunction

   // Code for the current word: block ID from the nibble address, or data.
   function automatic logic [9:0] code_of(
      input logic [5:0] idx,
      input logic data_half,
      input logic ext,
      input psq_pkg::psq_ident_t id
   );
      logic [9:0] c;
      c = `PSQ_ID_BASE - {6'h00, idx[3:0]};
      if (data_half) begin
         c = `PSQ_DATA_BASE - {6'h00, nibble_of(idx, ext, id)};
      end
      return c;
   endfunction

   // ==========================================================
   // Sync pulse synchroniser and slot tick.
   // ==========================================================
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sync_s1_reg <= 1'b0;
         sync_s2_reg <= 1'b0;
         sync_s3_reg <= 1'b0;
      end else begin
         sync_s1_reg <= SYNC_PULSE;
         sync_s2_reg <= sync_s1_reg;
         sync_s3_reg <= sync_s2_reg;
      end
   end

   // One word slot per sync pulse edge or per free-running period.
   always_ff @(posedge CLK_SYS) begin
      if (RST || state_reg != psq_pkg::ST_PHASE2) begin
         div_reg <= 32'h0;
         tick_reg <= 1'b0;
      end else if (mode_sync_reg) begin
         div_reg <= 32'h0;
         tick_reg <= sync_s2_reg && !sync_s3_reg;
      end else if (div_reg == ASYNC_PERIOD_CYC - 1) begin
         div_reg <= 32'h0;
         tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 32'h1;
         tick_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Phase 1 timeline and phase control.
   // ==========================================================
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         timer_reg <= 32'h0;
      end else if (timer_reg != 32'hffffffff) begin
         timer_reg <= timer_reg + 32'h1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_reg <= psq_pkg::ST_SETTLE;
         mode_sync_reg <= 1'b0;
         ext_reg <= 1'b0;
      end else begin
         case (state_reg)
            psq_pkg::ST_SETTLE: begin
               if (timer_reg >= SETTLE_CYC) begin
                  state_reg <= psq_pkg::ST_FILTER;
               end
            end
            psq_pkg::ST_FILTER: begin
               if (timer_reg >= FILT_START_CYC) begin
                  state_reg <= psq_pkg::ST_PME;
               end
            end
            psq_pkg::ST_PME: begin
               if (PROG_ENTRY_DET) begin
                  state_reg <= psq_pkg::ST_PROG;
               end else if (timer_reg >= PME_END_CYC) begin
                  state_reg <= psq_pkg::ST_WAIT2;
               end
            end
            psq_pkg::ST_WAIT2: begin
               if (timer_reg >= INIT2_CYC) begin
                  state_reg <= psq_pkg::ST_PHASE2;
                  mode_sync_reg <= SYNC_MODE;
                  ext_reg <= EXTENDED_FIELD_COUNT_SEL;
               end
            end
            psq_pkg::ST_PHASE2: begin
               if (busy_reg && slot_reg == `PSQ_LAST_SLOT && (!slot_on || buf_ready) && last_word) begin
                  state_reg <= psq_pkg::ST_DONE;
               end
            end
            default: begin
               state_reg <= state_reg;
            end
         endcase
      end
   end

   // ==========================================================
   // Phase 2 sequence position.
   // ==========================================================
   assign k_val = mode_sync_reg ? `PSQ_K_SYNC : `PSQ_K_ASYNC;
   assign n_fields = ext_reg ? `PSQ_FIELDS_EXT : `PSQ_FIELDS_STD;
   assign last_word = half_reg && rep_reg == k_val - 4'h1 && field_reg == n_fields - 6'h01;
   assign slot_on = mode_sync_reg ? SLOT_EN[slot_reg] : slot_reg == 2'h0;
   assign push = busy_reg && slot_on;
   assign buf_in.slot = slot_reg;
   assign buf_in.code = word_reg;

   // A tick that lands while the previous word is still going out is skipped.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         busy_reg <= 1'b0;
         slot_reg <= 2'h0;
         word_reg <= `PSQ_ID_BASE;
      end else if (!busy_reg) begin
         if (tick_reg && state_reg == psq_pkg::ST_PHASE2) begin
            busy_reg <= 1'b1;
            slot_reg <= 2'h0;
            word_reg <= code_of(field_reg, half_reg, ext_reg, IDENT);
         end
      end else if (!slot_on || buf_ready) begin
         slot_reg <= slot_reg + 2'h1;
         if (slot_reg == `PSQ_LAST_SLOT) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // ID word, then data word; the pair k times; then the next field.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         field_reg <= 6'h00;
         rep_reg <= 4'h0;
         half_reg <= 1'b0;
      end else if (busy_reg && slot_reg == `PSQ_LAST_SLOT && (!slot_on || buf_ready)) begin
         half_reg <= !half_reg;
         if (half_reg) begin
            if (rep_reg == k_val - 4'h1) begin
               rep_reg <= 4'h0;
               if (field_reg != n_fields - 6'h01) begin
                  field_reg <= field_reg + 6'h01;
               end
            end else begin
               rep_reg <= rep_reg + 4'h1;
            end
         end
      end
   end

   // ==========================================================
   // Status outputs.
   // ==========================================================
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         SELF_CHECK_EN <= 1'b0;
         REF_FILTER_START <= 1'b0;
         PROG_WINDOW_OPEN <= 1'b0;
         PROG_MODE <= 1'b0;
         PHASE2_ACTIVE <= 1'b0;
         PHASE2_DONE <= 1'b0;
      end else begin
         SELF_CHECK_EN <= state_reg != psq_pkg::ST_SETTLE && state_reg != psq_pkg::ST_PROG;
         REF_FILTER_START <= state_reg == psq_pkg::ST_SETTLE && timer_reg >= SETTLE_CYC;
         PROG_WINDOW_OPEN <= state_reg == psq_pkg::ST_PME;
         PROG_MODE <= state_reg == psq_pkg::ST_PROG;
         PHASE2_ACTIVE <= state_reg == psq_pkg::ST_PHASE2;
         PHASE2_DONE <= state_reg == psq_pkg::ST_DONE;
      end
   end

   // ==========================================================
   // Output buffer; nothing is pushed before phase 2.
   // ==========================================================
   psq_word_buffer #(
      .WIDTH($bits(psq_pkg::psq_tx_t))
   ) u_buf (
      .clk(CLK_SYS),
      .rst(RST),
      .in_valid(push),
      .in_ready_reg(buf_ready),
      .in_data(buf_in),
      .out_valid_reg(TX_VALID),
      .out_ready(TX_READY),
      .out_data_reg(TX_DATA)
   );

endmodule

// file: testbench/psq_init_seq_properties.sv
`timescale 1ns/100ps

// ==========================================================
// Port-level checker for the start-up sequencer.
// ==========================================================
module psq_init_seq_checker (
   input wire logic CLK_SYS,                  // Clock.
   input wire logic RST,                      // Reset.
   input wire logic SYNC_MODE,                // Mode.
   input wire logic EXTENDED_FIELD_COUNT_SEL, // Field count.
   input wire logic [3:0] SLOT_EN,            // Slots.
   input wire logic SYNC_PULSE,               // Sync pin.
   input wire logic PROG_ENTRY_DET,           // Entry seen.
   input wire psq_pkg::psq_ident_t IDENT,     // Identity bytes.
   input wire logic TX_VALID,                 // Word offered.
   input wire logic TX_READY,                 // Word taken.
   input wire psq_pkg::psq_tx_t TX_DATA,      // Word.
   input wire logic SELF_CHECK_EN,            // Self checks.
   input wire logic REF_FILTER_START,         // Filter start.
   input wire logic PROG_WINDOW_OPEN,         // Entry window.
   input wire logic PROG_MODE,                // Programming.
   input wire logic PHASE2_ACTIVE,            // Phase 2.
   input wire logic PHASE2_DONE               // Phase 2 over.
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RST);

   sequence s_stall;
      TX_VALID && !TX_READY;
   endsequence
   sequence s_held;
      TX_VALID && $stable(TX_DATA);
   endsequence
   property p_word_held;
      s_stall |=> s_held;
   endproperty
   property p_quiet_phase1;
      !PHASE2_ACTIVE && !PHASE2_DONE |-> !TX_VALID;
   endproperty
   property p_filter_pulse;
      REF_FILTER_START |-> !PROG_WINDOW_OPEN && !PHASE2_ACTIVE ##1 !REF_FILTER_START [*8];
   endproperty
   property p_window_after_filter;
      $rose(PROG_WINDOW_OPEN) |-> SELF_CHECK_EN && !PHASE2_ACTIVE;
   endproperty
   property p_phase2_checks;
      PHASE2_ACTIVE |-> SELF_CHECK_EN;
   endproperty
   property p_prog_halts;
      PROG_MODE |-> !PHASE2_ACTIVE && !PHASE2_DONE && !TX_VALID;
   endproperty
   property p_phase2_entry;
      $rose(PHASE2_ACTIVE) |-> !PROG_WINDOW_OPEN && !PROG_MODE;
   endproperty
   property p_code_range;
      TX_VALID |-> TX_DATA.code[9:5] == 5'h10;
   endproperty
   property p_async_slot;
      TX_VALID && !SYNC_MODE |-> TX_DATA.slot == 2'h0;
   endproperty
   property p_sync_slot;
      TX_VALID && SYNC_MODE |-> SLOT_EN[TX_DATA.slot];
   endproperty
   property p_done_sticky;
      PHASE2_DONE |=> PHASE2_DONE && !PHASE2_ACTIVE;
   endproperty

   a_word_held: assert property (p_word_held) else $error("offered word changed before it was taken");
   a_quiet_phase1: assert property (p_quiet_phase1) else $error("word offered before phase 2");
   a_filter_pulse: assert property (p_filter_pulse) else $error("filter start pulse misplaced");
   a_window_after_filter: assert property (p_window_after_filter) else $error("window opened early");
   a_phase2_checks: assert property (p_phase2_checks) else $error("self checks off in phase 2");
   a_prog_halts: assert property (p_prog_halts) else $error("phase 2 ran in programming mode");
   a_phase2_entry: assert property (p_phase2_entry) else $error("phase 2 entered from window");
   a_code_range: assert property (p_code_range) else $error("word outside init codes");
   a_async_slot: assert property (p_async_slot) else $error("async word not in slot 0");
   a_sync_slot: assert property (p_sync_slot) else $error("word in disabled slot");
   a_done_sticky: assert property (p_done_sticky) else $error("phase 2 end not sticky");
endmodule

bind psq_init_seq psq_init_seq_checker u_checker (.CLK_SYS(CLK_SYS), .RST(RST), .SYNC_MODE(SYNC_MODE),
   .EXTENDED_FIELD_COUNT_SEL(EXTENDED_FIELD_COUNT_SEL), .SLOT_EN(SLOT_EN), .SYNC_PULSE(SYNC_PULSE),
   .PROG_ENTRY_DET(PROG_ENTRY_DET), .IDENT(IDENT), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
   .SELF_CHECK_EN(SELF_CHECK_EN), .REF_FILTER_START(REF_FILTER_START), .PROG_WINDOW_OPEN(PROG_WINDOW_OPEN),
   .PROG_MODE(PROG_MODE), .PHASE2_ACTIVE(PHASE2_ACTIVE), .PHASE2_DONE(PHASE2_DONE));

// file: testbench/psq_link_receiver.sv
`timescale 1ns/100ps

// ==========================================================
// Control unit receiver: sync pulses and a stalling sink.
// ==========================================================
module psq_link_receiver #(
   parameter int SYNC_PERIOD = 60,
   parameter int STALL = 4
) (
   input wire logic clk,      // Clock.
   input wire logic rst,      // Reset.
   input wire logic sync_on,  // Send sync pulses.
   input wire logic tx_valid, // Word offered.
   output logic tx_ready = 1'b1,  // Word accepted.
   output logic sync_pulse = 1'b0 // Sync pulse, low outside pulses.
);
   int period_cnt = 0;
   int taken = 0;
   int stall_cnt = 0;

   always @(posedge clk) begin
      if (rst || !sync_on) begin
         period_cnt <= 0;
         sync_pulse <= 1'b0;
      end else begin
         period_cnt <= (period_cnt == SYNC_PERIOD - 1) ? 0 : period_cnt + 1;
         sync_pulse <= (period_cnt < 2);
      end
   end

   // Every fifth word taken is followed by a stall, so the buffer must hold its word.
   always @(posedge clk) begin
      if (rst) begin
         tx_ready <= 1'b1;
         stall_cnt <= 0;
         taken <= 0;
      end else if (stall_cnt != 0) begin
         stall_cnt <= stall_cnt - 1;
         tx_ready <= (stall_cnt == 1);
      end else if (tx_valid && tx_ready) begin
         taken <= taken + 1;
         if (taken % 5 == 4) begin
            tx_ready <= 1'b0;
            stall_cnt <= STALL;
         end
      end
   end
endmodule

// file: testbench/psq_init_seq_tb_top.sv
`timescale 1ns/100ps

module psq_init_seq_tb_top;
   localparam int SETTLE = 20;
   localparam int FILT = 30;
   localparam int PME = 200;
   localparam int INIT2 = 250;
   localparam int APER = 40;
   localparam int SPER = 60;
   localparam psq_pkg::psq_ident_t ID_A = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
   // Nibble source per index: identity byte times two, plus one for the high half.
   localparam logic [4:0] NIB_SEL [32] = '{5'h0e, 5'h00, 5'h00, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16,
      5'h17, 5'h18, 5'h19, 5'h1a, 5'h1c, 5'h1d, 5'h1e, 5'h1f, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07,
      5'h06, 5'h05, 5'h04, 5'h02, 5'h01, 5'h00, 5'h1b};
   logic clk_sys, rst, sync_mode, ext_sel, sync_pulse, prog_det, tx_valid, tx_ready, sync_on;
   logic self_chk, filt_start, win_open, prog_mode, p2_active, p2_done;
   logic [3:0] slot_en;
   psq_pkg::psq_ident_t ident;
   psq_pkg::psq_tx_t tx_data;
   psq_pkg::psq_tx_t taken_q[$];
   int n_errors = 0;
   int checks_done = 0;
   int filt_pulses = 0;
   int win_cycles = 0;

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         taken_q.push_back(tx_data);
      if (filt_start === 1'b1)
         filt_pulses++;
      if (win_open === 1'b1)
         win_cycles++;
   end

   psq_init_seq #(.SETTLE_CYC(SETTLE), .FILT_START_CYC(FILT), .PME_END_CYC(PME), .INIT2_CYC(INIT2),
      .ASYNC_PERIOD_CYC(APER)) dut (.CLK_SYS(clk_sys), .RST(rst), .SYNC_MODE(sync_mode),
      .EXTENDED_FIELD_COUNT_SEL(ext_sel), .SLOT_EN(slot_en), .SYNC_PULSE(sync_pulse), .PROG_ENTRY_DET(prog_det),
      .IDENT(ident), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data), .SELF_CHECK_EN(self_chk),
      .REF_FILTER_START(filt_start), .PROG_WINDOW_OPEN(win_open), .PROG_MODE(prog_mode),
      .PHASE2_ACTIVE(p2_active), .PHASE2_DONE(p2_done));

   psq_link_receiver #(.SYNC_PERIOD(SPER)) partner (.clk(clk_sys), .rst(rst), .sync_on(sync_on),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .sync_pulse(sync_pulse));

   // ==========================================================
   // Shared tasks.
   // ==========================================================
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      if (n_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wait_high(ref logic sig, input int limit, output int cycles);
      cycles = 0;
      while (sig !== 1'b1) begin
         if (cycles == limit) begin
            n_errors++;
            $display("FAIL wait expected 1 seen %b", sig);
            complete_run();
         end
         @(negedge clk_sys);
         cycles++;
      end
   endtask

   task automatic start(input logic smode, input logic ext, input logic [3:0] en, input psq_pkg::psq_ident_t id);
      @(posedge clk_sys);
      rst <= 1'b1;
      sync_mode <= smode;
      ext_sel <= ext;
      slot_en <= en;
      ident <= id;
      sync_on <= smode;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      taken_q.delete();
      filt_pulses = 0;
      win_cycles = 0;
   endtask

   // ==========================================================
   // Scenarios.
   // ==========================================================
   task automatic run_phase2(input logic smode, input logic ext, input logic [3:0] en, input psq_pkg::psq_ident_t id);
      int k, f, per, t0, dur;
      logic [3:0] nb;
      logic [3:0] act;
      logic [9:0] w;
      psq_pkg::psq_tx_t exp_q[$];
      k = smode ? 4 : 8;
      f = ext ? 48 : 32;
      per = smode ? SPER : APER;
      act = smode ? en : 4'h1;
      start(smode, ext, en, id);
      @(posedge clk_sys);
      prog_det <= 1'b1;
      @(posedge clk_sys);
      prog_det <= 1'b0;
      wait_high(p2_active, INIT2 + 10, t0);
      check("phase 2 start", 16'(t0 >= INIT2 - 4 && t0 <= INIT2 + 4), 16'h1);
      check("filter start pulses", 16'(filt_pulses), 16'h1);
      check("entry window", 16'(win_cycles >= PME - FILT - 2 && win_cycles <= PME - FILT + 2), 16'h1);
      check("early entry ignored", 16'(prog_mode), 16'h0);
      wait_high(p2_done, 30000, dur);
      check("phase 2 time", 16'(dur >= (2 * k * f - 1) * per && dur <= (2 * k * f + 1) * per), 16'h1);
      repeat (8) @(negedge clk_sys);
      check("phase 2 active", 16'(p2_active), 16'h0);
      for (int i = 0; i < f; i++) begin
         nb = id[4 * NIB_SEL[5'(i % 32)] +: 4];
         if (i == 1) begin
            nb = ext ? 4'h3 : 4'h2;
         end else if (i == 2 || i > 31) begin
            nb = 4'h0;
         end
         for (int r = 0; r < 2 * k; r++) begin
            w = r[0] ? 10'h21f - 10'(nb) : 10'h20f - 10'(i % 16);
            for (int s = 0; s < 4; s++) begin
               if (act[s])
                  exp_q.push_back({2'(s), w});
            end
         end
      end
      check("word count", 16'(taken_q.size()), 16'(exp_q.size()));
      for (int n = 0; n < exp_q.size() && n < taken_q.size(); n++)
         check("word", 16'(taken_q[n]), 16'(exp_q[n]));
   endtask

   task automatic prog_entry;
      int t;
      start(1'b0, 1'b0, 4'h1, ID_A);
      wait_high(win_open, FILT + 10, t);
      @(posedge clk_sys);
      prog_det <= 1'b1;
      wait_high(prog_mode, 10, t);
      @(posedge clk_sys);
      prog_det <= 1'b0;
      repeat (INIT2 + 100) @(negedge clk_sys);
      check("programming mode", 16'(prog_mode), 16'h1);
      check("phase 2 blocked", 16'(p2_active), 16'h0);
      check("words sent", 16'(taken_q.size()), 16'h0);
   endtask

   initial begin
      rst = 1'b1;
      sync_mode = 1'b0;
      ext_sel = 1'b0;
      slot_en = 4'h0;
      prog_det = 1'b0;
      ident = ID_A;
      sync_on = 1'b0;
      run_phase2(1'b0, 1'b0, 4'hf, ID_A);
      run_phase2(1'b1, 1'b1, 4'h5, ~ID_A);
      prog_entry();
      complete_run();
   end
endmodule
